// ===== hdl/processor_supervisor_watchdog.sv
module processor_supervisor_watchdog #(
   parameter supervisor_pkg::cnt_t PB_DELAY_CYC = supervisor_pkg::PB_DELAY_CYC,
   parameter supervisor_pkg::cnt_t RESET_HOLD_CYC = supervisor_pkg::RESET_HOLD_CYC,
   parameter supervisor_pkg::cnt_t WDT_SHORT_CYC = supervisor_pkg::WDT_SHORT_CYC,
   parameter supervisor_pkg::cnt_t WDT_MID_CYC = supervisor_pkg::WDT_MID_CYC,
   parameter supervisor_pkg::cnt_t WDT_LONG_CYC = supervisor_pkg::WDT_LONG_CYC
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic pushbutton_reset_n_i,
   input wire logic watchdog_strobe_n_i,
   input wire logic [1:0] watchdog_timebase_sel_i,
   input wire logic supply_tolerance_sel_i,
   input wire logic supply_below_5pct_i,
   input wire logic supply_below_10pct_i,
   output logic reset_o,
   output logic reset_n_o,
   output logic reset_n_oe_o
);

   // ---------------------------------------------------------------
   // Timeout decode
   // ---------------------------------------------------------------
   // Unused select code falls back to the middle timebase
   function automatic supervisor_pkg::cnt_t timeout_cyc(input logic [1:0] sel);
      supervisor_pkg::cnt_t t;
      unique case (sel)
         supervisor_pkg::TB_LOW: t = WDT_SHORT_CYC;
         supervisor_pkg::TB_OPEN: t = WDT_MID_CYC;
         supervisor_pkg::TB_HIGH: t = WDT_LONG_CYC;
         default: t = WDT_MID_CYC;
      endcase
      return t; // R2
   endfunction

   supervisor_pkg::state_t state_r;
   supervisor_pkg::state_t state_nxt;

   logic pb_low;
   logic supply_bad;
   logic st_fall;
   logic wdt_fire;
   supervisor_pkg::cnt_t wdt_limit;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;

      // Two-flop synchronisers for every pin but clk_i, sys_rst_i and clk_en_i
      state_nxt.pb_sync = {state_r.pb_sync[0], pushbutton_reset_n_i};
      state_nxt.st_sync = {state_r.st_sync[0], watchdog_strobe_n_i};
      state_nxt.tol_sync = {state_r.tol_sync[0], supply_tolerance_sel_i};
      state_nxt.lo5_sync = {state_r.lo5_sync[0], supply_below_5pct_i};
      state_nxt.lo10_sync = {state_r.lo10_sync[0], supply_below_10pct_i};
      state_nxt.tb_meta = watchdog_timebase_sel_i;
      state_nxt.tb_sync = state_r.tb_meta;

      pb_low = ~state_r.pb_sync[1];

      // Trip level chosen by tolerance select
      if (state_r.tol_sync[1])
      begin
         supply_bad = state_r.lo10_sync[1]; // R3
      end
      else
      begin
         supply_bad = state_r.lo5_sync[1]; // R3
      end

      // Falling edge only; rising edges and levels pass unseen
      st_fall = state_r.st_prev & ~state_r.st_sync[1]; // R9
      state_nxt.st_prev = state_r.st_sync[1];

      // -------------------------------------------------------------
      // Pushbutton debounce
      // -------------------------------------------------------------
      // A qualify time of a few ms rejects bounce yet lands well before 20ms
      if (!pb_low)
      begin
         state_nxt.pb_cnt = supervisor_pkg::CNT_ZERO; // R1
         state_nxt.pb_active = 1'b0;
      end
      else if (!state_r.pb_active)
      begin
         if (state_r.pb_cnt == PB_DELAY_CYC - supervisor_pkg::CNT_ONE)
         begin
            state_nxt.pb_active = 1'b1; // R7
         end
         else
         begin
            state_nxt.pb_cnt = state_r.pb_cnt + supervisor_pkg::CNT_ONE; // R1 R13
         end
      end

      // -------------------------------------------------------------
      // Watchdog
      // -------------------------------------------------------------
      wdt_limit = timeout_cyc(state_r.tb_sync);
      wdt_fire = !state_r.rst && !st_fall &&
         (state_r.wdt_cnt == wdt_limit - supervisor_pkg::CNT_ONE); // R11 R13

      if (state_r.rst || st_fall || wdt_fire)
      begin
         state_nxt.wdt_cnt = supervisor_pkg::CNT_ZERO; // R9 R14
      end
      else
      begin
         state_nxt.wdt_cnt = state_r.wdt_cnt + supervisor_pkg::CNT_ONE;
      end

      // -------------------------------------------------------------
      // Reset hold
      // -------------------------------------------------------------
      // Each cause reloads the hold, so the 250ms counts from its end
      state_nxt.powerup = 1'b0;
      if (state_r.powerup || supply_bad || state_r.pb_active || wdt_fire)
      begin
         state_nxt.hold_cnt = RESET_HOLD_CYC; // R4 R6 R8 R10
      end
      else if (state_r.hold_cnt != supervisor_pkg::CNT_ZERO)
      begin
         state_nxt.hold_cnt = state_r.hold_cnt - supervisor_pkg::CNT_ONE; // R13
      end

      state_nxt.rst = (state_nxt.hold_cnt != supervisor_pkg::CNT_ZERO); // R4
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_r <= supervisor_pkg::STATE_RESET;
      end
      else if (clk_en_i)
      begin
         state_r <= state_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Open drain only ever pulls low; the board pull-up gives the high level
   assign reset_o = state_r.rst; // R4
   assign reset_n_o = 1'b0; // R5
   assign reset_n_oe_o = state_r.rst; // R5

endmodule // processor_supervisor_watchdog

// ===== hdl/supervisor_pkg.sv
// Functional notes
// R1: Pushbutton ignores under 1ms, honours 20ms.
// R2: Timebase select picks 150ms/600ms/1.2s timeout.
// R3: Tolerance select picks 5% or 10% trip.
// R4: Reset on power-up, brownout, button, watchdog.
// R5: Active-low output is open-drain inverse.
// R6: Release only after 250ms continuous good supply.
// R7: Button must stay low for delay first.
// R8: Hold reset 250ms after button release.
// R9: Only strobe falling edges restart watchdog.
// R10: Watchdog timeout gives 250ms reset pulse.
// R11: Repeat pulses each timeout until strobed.
// R12: Host strobes faster than selected timeout.
// R13: All intervals counted from internal clock.
// R14: Watchdog counter cleared while reset drives.
package supervisor_pkg;

   // ---------------------------------------------------------------
   // Timebase
   // ---------------------------------------------------------------
   localparam int unsigned CLK_KHZ = 200000;
   localparam int unsigned CNT_W = 28;
   typedef logic [CNT_W-1:0] cnt_t;

   // Debounce qualify time sits between the 1ms floor and 20ms ceiling
   localparam int unsigned PB_DELAY_MS = 4;
   localparam int unsigned RESET_HOLD_MS = 250;
   localparam int unsigned WDT_SHORT_MS = 150;
   localparam int unsigned WDT_MID_MS = 600;
   localparam int unsigned WDT_LONG_MS = 1200;

   localparam cnt_t PB_DELAY_CYC = cnt_t'(PB_DELAY_MS * CLK_KHZ);
   localparam cnt_t RESET_HOLD_CYC = cnt_t'(RESET_HOLD_MS * CLK_KHZ);
   localparam cnt_t WDT_SHORT_CYC = cnt_t'(WDT_SHORT_MS * CLK_KHZ);
   localparam cnt_t WDT_MID_CYC = cnt_t'(WDT_MID_MS * CLK_KHZ);
   localparam cnt_t WDT_LONG_CYC = cnt_t'(WDT_LONG_MS * CLK_KHZ);

   localparam cnt_t CNT_ZERO = cnt_t'(0);
   localparam cnt_t CNT_ONE = cnt_t'(1);

   // ---------------------------------------------------------------
   // Three-state timebase select encoding
   // ---------------------------------------------------------------
   localparam logic [1:0] TB_LOW = 2'h0;
   localparam logic [1:0] TB_OPEN = 2'h1;
   localparam logic [1:0] TB_HIGH = 2'h2;

   localparam logic [1:0] SYNC_HIGH = 2'h3;
   localparam logic [1:0] SYNC_LOW = 2'h0;

   // ---------------------------------------------------------------
   // Module state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] pb_sync;
      logic [1:0] st_sync;
      logic st_prev;
      logic [1:0] tol_sync;
      logic [1:0] lo5_sync;
      logic [1:0] lo10_sync;
      logic [1:0] tb_meta;
      logic [1:0] tb_sync;
      cnt_t pb_cnt;
      logic pb_active;
      cnt_t hold_cnt;
      cnt_t wdt_cnt;
      logic powerup;
      logic rst;
   } state_t;

   // Supply treated as bad and reset asserted until the first hold expires
   localparam state_t STATE_RESET = '{
      pb_sync: SYNC_HIGH,
      st_sync: SYNC_HIGH,
      st_prev: 1'b1,
      tol_sync: SYNC_LOW,
      lo5_sync: SYNC_HIGH,
      lo10_sync: SYNC_HIGH,
      tb_meta: TB_LOW,
      tb_sync: TB_LOW,
      pb_cnt: CNT_ZERO,
      pb_active: 1'b0,
      hold_cnt: CNT_ZERO,
      wdt_cnt: CNT_ZERO,
      powerup: 1'b1,
      rst: 1'b1
   };

endpackage

// ===== test/host_strobe_model.sv
module host_strobe_model (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic [5:0] period_i,
   output logic strobe_n_o = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] cnt_r = '0;
   // Stopped host leaves the line at its last level, a static level
   always @(posedge clk_i)
      if (!run_i)
         cnt_r <= '0;
      else if (cnt_r >= period_i)
      begin
         cnt_r <= '0;
         strobe_n_o <= #1 !strobe_n_o;
      end
      else
         cnt_r <= cnt_r + 6'h1;
endmodule // host_strobe_model

// ===== test/processor_supervisor_watchdog_tb_top.sv
module processor_supervisor_watchdog_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 32'h32;
   logic clk_i = 0, sys_rst_i = 1, pb_n = 1, supply_tolerance_sel = 0, b5 = 0, b10 = 0, run = 0, rst, st_n;
   logic [1:0] sel = 2'h0;
   logic rn, roe;
   logic [15:0] lfsr = 16'h659d;
   int errors = 0, num_checks = 0, w = 0;
   int exp_q[$];
   processor_supervisor_watchdog #(.PB_DELAY_CYC(28'h14), .RESET_HOLD_CYC(28'(HOLD)),
      .WDT_SHORT_CYC(28'h64), .WDT_MID_CYC(28'hc8), .WDT_LONG_CYC(28'h12c)) dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .pushbutton_reset_n_i(pb_n),
      .watchdog_strobe_n_i(st_n), .watchdog_timebase_sel_i(sel), .supply_tolerance_sel_i(supply_tolerance_sel),
      .supply_below_5pct_i(b5), .supply_below_10pct_i(b10), .reset_o(rst), .reset_n_o(rn),
      .reset_n_oe_o(roe));
   host_strobe_model host (.clk_i(clk_i), .run_i(run), .period_i(6'h8 + 6'(lfsr % 20)),
      .strobe_n_o(st_n));
   initial forever #2.5 clk_i = ~clk_i;
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task check(string n, logic s, logic e);
      num_checks++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] %s exp %b seen %b", n, e, s);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task tick(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task wait_idle(string n, int lim);
      int i;
      for (i = 0; i < lim && (exp_q.size() != 0 || rst !== 1'b0); i++)
         tick(1);
      check({n, " done"}, i < lim, 1'b1);
      if (i == lim)
         print_verdict();
      else
         $display("test %s done", n);
   endtask
   // Each finished reset pulse is matched against the oldest expectation
   // Sampled mid-cycle so the value launched by the rising edge has settled
   always @(negedge clk_i)
      if (sys_rst_i)
         w = 0;
      else if (rst === 1'b1)
         w++;
      else if (w > 0)
      begin
         if (exp_q.size() == 0)
            check("unexpected pulse", 1'b1, 1'b0);
         else
            check("pulse width", w >= exp_q.pop_front(), 1'b1);
         w = 0;
      end
   initial
   begin
      exp_q.push_back(HOLD);
      tick(10);
      sys_rst_i = 0;
      run = 1;
      wait_idle("power-up", 200);
      repeat (3)
      begin
         lfsr = lfsr_next(lfsr);
         pb_n = 0;
         tick(1 + lfsr % 12);
         pb_n = 1;
         tick(30);
         check("short press", rst, 1'b0);
      end
      $display("test short press done");
      exp_q.push_back(HOLD);
      pb_n = 0;
      tick(40);
      check("button", rst, 1'b1);
      check("open drain low", roe ? rn : 1'b1, 1'b0);
      pb_n = 1;
      tick(45);
      check("button hold", rst, 1'b1);
      wait_idle("button", 100);
      for (int t = 0; t < 2; t++)
      begin
         supply_tolerance_sel = t[0];
         tick(5);
         {b5, b10} = supply_tolerance_sel ? 2'b10 : 2'b01;
         tick(20);
         check("other comparator", rst, 1'b0);
         exp_q.push_back(HOLD);
         {b5, b10} = supply_tolerance_sel ? 2'b01 : 2'b10;
         tick(10);
         check("supply low", rst, 1'b1);
         {b5, b10} = 2'b00;
         tick(40);
         check("supply hold", rst, 1'b1);
         wait_idle("supply", 100);
      end
      for (int s = 0; s < 3; s++)
      begin
         sel = s[1:0];
         tick(5);
         run = 0;
         exp_q.push_back(HOLD);
         exp_q.push_back(HOLD);
         wait_idle("watchdog", 1000);
         lfsr = lfsr_next(lfsr);
         run = 1;
      end
      tick(700);
      check("strobed", rst, 1'b0);
      check("open drain released", roe ? rn : 1'b1, 1'b1);
      $display("test strobed done");
      print_verdict();
   end
endmodule // processor_supervisor_watchdog_tb_top

// ===== test/supervisor_watch_properties.sv
module supervisor_watch_properties #(
   parameter supervisor_pkg::cnt_t PB_DELAY_CYC = 20,
   parameter supervisor_pkg::cnt_t RESET_HOLD_CYC = 50,
   parameter supervisor_pkg::cnt_t WDT_SHORT_CYC = 100,
   parameter supervisor_pkg::cnt_t WDT_MID_CYC = 200,
   parameter supervisor_pkg::cnt_t WDT_LONG_CYC = 300
)
(
   input wire logic clk_i, sys_rst_i, clk_en_i, pushbutton_reset_n_i, watchdog_strobe_n_i,
   input wire logic [1:0] watchdog_timebase_sel_i,
   input wire logic supply_tolerance_sel_i, supply_below_5pct_i, supply_below_10pct_i,
   input wire logic reset_o, reset_n_o, reset_n_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic bad, st_r;
   logic [27:0] hi_r, pl_r, q_r, lim;
   assign bad = supply_tolerance_sel_i ? supply_below_10pct_i : supply_below_5pct_i;
   assign lim = (watchdog_timebase_sel_i == 2'h0) ? WDT_SHORT_CYC :
                (watchdog_timebase_sel_i == 2'h2) ? WDT_LONG_CYC : WDT_MID_CYC;
   // q_r counts quiet cycles; a raw strobe fall clears it before the design sees it
   always_ff @(posedge clk_i or posedge sys_rst_i)
      if (sys_rst_i)
      begin
         {hi_r, pl_r, q_r, st_r} <= '0;
      end
      else if (clk_en_i)
      begin
         st_r <= watchdog_strobe_n_i;
         hi_r <= reset_o ? hi_r + 28'h1 : '0;
         pl_r <= pushbutton_reset_n_i ? '0 : pl_r + 28'h1;
         q_r <= (reset_o || bad || (st_r && !watchdog_strobe_n_i)) ? '0 : q_r + 28'h1;
      end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence supply_lost; bad [*4]; endsequence
   a_oe_mirror: assert property (reset_n_oe_o == reset_o)
      else $error("open-drain enable differs from reset");
   a_drain_low: assert property (reset_n_o == 1'b0)
      else $error("open-drain data not low");
   a_supply_trip: assert property (supply_lost |=> reset_o)
      else $error("bad supply without reset");
   a_supply_hold: assert property (supply_lost ##1 !bad |-> reset_o [*8])
      else $error("reset dropped right after supply recovered");
   a_button_trip: assert property (pl_r >= PB_DELAY_CYC + 5 |-> reset_o)
      else $error("long button press without reset");
   a_hold_min: assert property ($fell(reset_o) |-> hi_r >= RESET_HOLD_CYC)
      else $error("reset pulse too short");
   a_wdt_early: assert property ($rose(reset_o) && pushbutton_reset_n_i && q_r >= 10
      |-> q_r >= lim - 2)
      else $error("watchdog fired early");
   a_wdt_fires: assert property (q_r <= lim + 6)
      else $error("watchdog missed timeout");
endmodule // supervisor_watch_properties

bind processor_supervisor_watchdog supervisor_watch_properties #(.PB_DELAY_CYC(PB_DELAY_CYC),
   .RESET_HOLD_CYC(RESET_HOLD_CYC), .WDT_SHORT_CYC(WDT_SHORT_CYC),
   .WDT_MID_CYC(WDT_MID_CYC), .WDT_LONG_CYC(WDT_LONG_CYC)) u_props (.*);
